// *** hdl/arb_pkg.sv ***
/*
  Constants shared by the pre-driver output access arbiter: sizes, register
  indices, grant field layout, reset values and control-set field positions.
  Assumes nothing of its surroundings.
*/
`default_nettype none
package arb_pkg;
  // Sizes
  localparam int N_CORES = 4;
  localparam int N_HS = 5;
  localparam int N_LS = 7;
  localparam int THR_W = 3;
  localparam int REG_W = 16;
  localparam int GRANT_W = N_HS + N_LS;

  // Register indices; the byte address on the bus is four times the index
  localparam logic [9:0] IDX_GRANT_C0_CH1 = 10'h184;
  localparam logic [9:0] IDX_GRANT_C1_CH1 = 10'h185;
  localparam logic [9:0] IDX_GRANT_C0_CH2 = 10'h186;
  localparam logic [9:0] IDX_GRANT_C1_CH2 = 10'h187;
  localparam logic [9:0] IDX_OUT_STATE = 10'h188;

  // Grant field layout inside each grant register
  localparam int GRANT_HS_LSB = 0;
  localparam int GRANT_LS_LSB = 5;

  // Grant reset values, core order chan1_core0 .. chan2_core1
  localparam logic [REG_W-1:0] RST_GRANT_C0_CH1 = 16'h0221;
  localparam logic [REG_W-1:0] RST_GRANT_C1_CH1 = 16'h0442;
  localparam logic [REG_W-1:0] RST_GRANT_C0_CH2 = 16'h0884;
  localparam logic [REG_W-1:0] RST_GRANT_C1_CH2 = 16'h0118;

  // Control set field positions; bit 0 is always the gate value
  localparam int F_GATE = 0;
  localparam int F_VDS_LSB = 1;
  localparam int F_FW = 4;
  localparam int F_EN_VDS = 5;
  localparam int F_SRC_LSB = 6;
  localparam int F_EN_SRC = 9;
  localparam int LS_SET_W = 6;
  localparam int HS_SET_W = 10;

  // Outputs that own a freewheel control
  localparam logic [N_LS-1:0] LS_FW_MASK = 7'h78;
  localparam logic [N_HS-1:0] HS_FW_MASK = 5'h10;
endpackage
`default_nettype wire

// *** hdl/core_req_if.sv ***
/*
  Request bundle for one pre-driver output: one change request, its control
  set, grant and lock state per core, and the merged control set back.
  Assumes a single clock domain shared by all cores and the arbiter.
*/
`default_nettype none
interface core_req_if #(
  parameter int N = 4,
  parameter int W = 6
);
  logic [N-1:0] req;
  logic [N-1:0] grant;
  logic [N-1:0] locked;
  logic [N-1:0][W-1:0] data;
  logic [W-1:0] q;
  modport src (output req, output grant, output locked, output data, input q);
  modport merge (input req, input grant, input locked, input data, output q);
endinterface
`default_nettype wire

// *** hdl/output_merge.sv ***
/*
  Merges the change requests of all cores for one output into one held
  control set. Assumes requests are single-cycle change strobes.
*/
`default_nettype none
module output_merge #(
  parameter int N = 4,
  parameter int W = 6
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Core requests and merged set
  core_req_if.merge port
);
  logic win_valid;
  logic [$clog2(N)-1:0] win_idx;
  logic pulse_r;
  logic [W-1:0] set_r;

  // Refuse sizes that the winner index cannot serve
  if (N < 2 || W < 1) begin : g_bad_size
    $error("output_merge: unsupported size");
  end

  // Lowest index wins, so scan downward and let later hits override
  always_comb begin
    win_valid = 1'b0;
    win_idx = '0;
    for (int c = N - 1; c >= 0; c--) begin
      if (port.req[c] && port.grant[c]) begin
        win_valid = 1'b1;
        win_idx = c[$clog2(N)-1:0];
      end
    end
  end

  // Each accepted change is applied in its own cycle, so changes in different cycles all land in order
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      set_r <= '0;
    end else if (win_valid) begin
      set_r <= port.data[win_idx];
    end else if (pulse_r) begin
      set_r[0] <= 1'b0;
    end
  end

  // An unlocked core may hold the gate on for one cycle only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pulse_r <= 1'b0;
    end else begin
      pulse_r <= win_valid && !port.locked[win_idx] && port.data[win_idx][0];
    end
  end

  assign port.q = set_r;
endmodule // output_merge
`default_nettype wire

// *** hdl/grant_regs.sv ***
/*
  APB slave holding the four grant registers and an output state readback.
  Assumes an APB master on the same clock; zero wait states.
*/
`default_nettype none
module grant_regs
  import arb_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Block side
  output logic [N_CORES-1:0][GRANT_W-1:0] grant,
  input wire logic [GRANT_W-1:0] out_state
);
  localparam logic [N_CORES-1:0][REG_W-1:0] RST_GRANTS =
    {RST_GRANT_C1_CH2, RST_GRANT_C0_CH2, RST_GRANT_C1_CH1, RST_GRANT_C0_CH1};

  logic [N_CORES-1:0][GRANT_W-1:0] grant_r;
  logic [31:0] rdata_nxt;
  logic [31:0] prdata_r;
  logic hit;
  logic is_grant;
  logic [9:0] idx;
  logic [1:0] sel;

  assign idx = paddr[11:2];
  assign sel = 2'(idx - IDX_GRANT_C0_CH1);
  assign is_grant = (paddr[1:0] == 2'h0) && (idx >= IDX_GRANT_C0_CH1) && (idx <= IDX_GRANT_C1_CH2);
  assign hit = is_grant || ((paddr[1:0] == 2'h0) && (idx == IDX_OUT_STATE));

  // Read data is captured in the setup phase so prdata comes from a flop
  always_comb begin
    rdata_nxt = 32'h0;
    if (is_grant) begin
      rdata_nxt[GRANT_W-1:0] = grant_r[sel];
    end else if (hit) begin
      rdata_nxt[GRANT_W-1:0] = out_state;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata_r <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      prdata_r <= rdata_nxt;
    end
  end

  generate
    for (genvar c = 0; c < N_CORES; c++) begin : g_grant
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          grant_r[c] <= RST_GRANTS[c][GRANT_W-1:0];
        end else if (psel && penable && pwrite && is_grant && sel == 2'(c)) begin
          grant_r[c] <= pwdata[GRANT_W-1:0];
        end
      end
    end
  endgenerate

  assign grant = grant_r;
  assign prdata = prdata_r;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;
endmodule // grant_regs
`default_nettype wire

// *** hdl/predriver_output_access_arbiter.sv ***
/*
  Merges gate-drive requests of four sequencer cores into one control set per
  high-side and low-side pre-driver output, gated by software grant registers.
  Assumes cores run on clk and issue one-cycle change requests; APB on clk.
*/
`default_nettype none

// Functional notes
// - Each low-side output gets a gate value, a 3-bit drain threshold, freewheel and drain-check enables.
// - Freewheel exists only on low-side outputs 4 to 7; the others drive it at zero.
// - Each high-side output gets a gate value, a 3-bit drain threshold and a 3-bit source threshold.
// - Of the high-side outputs only output 5 has freewheel.
// - Drain-check and, on high sides, source-check enables pass through to the coherency checker.
// - Each core presents seven low-side and five high-side request sets.
// - Requests of the four cores merge into one set per output, admitted only by the grant registers.
// - A grant bit at one lets its core drive every control of its output; at zero the core is ignored.
// - The four grant registers sit at consecutive indices from chan1_core0 to chan2_core1.
// - Same-cycle collisions go to chan1_core0, chan1_core1, chan2_core0, chan2_core1 in that order.
// - A switch-on from an unlocked core lasts one cycle, then the gate is forced off.
module predriver_output_access_arbiter
  import arb_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // APB register port
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Core lock state, core order chan1_core0 .. chan2_core1
  input wire logic [N_CORES-1:0] core_locked,
  // Low-side requests per core
  input wire logic [N_CORES-1:0][N_LS-1:0] ls_req,
  input wire logic [N_CORES-1:0][N_LS-1:0] ls_gate_in,
  input wire logic [N_CORES-1:0][N_LS-1:0][THR_W-1:0] ls_vds_thr_in,
  input wire logic [N_CORES-1:0][N_LS-1:0] ls_fw_in,
  input wire logic [N_CORES-1:0][N_LS-1:0] ls_en_vds_in,
  // High-side requests per core
  input wire logic [N_CORES-1:0][N_HS-1:0] hs_req,
  input wire logic [N_CORES-1:0][N_HS-1:0] hs_gate_in,
  input wire logic [N_CORES-1:0][N_HS-1:0][THR_W-1:0] hs_vds_thr_in,
  input wire logic [N_CORES-1:0][N_HS-1:0][THR_W-1:0] hs_src_thr_in,
  input wire logic [N_CORES-1:0][N_HS-1:0] hs_fw_in,
  input wire logic [N_CORES-1:0][N_HS-1:0] hs_en_vds_in,
  input wire logic [N_CORES-1:0][N_HS-1:0] hs_en_src_in,
  // Low-side pre-driver controls
  output logic [N_LS-1:0] ls_gate,
  output logic [N_LS-1:0][THR_W-1:0] ls_vds_thr,
  output logic [N_LS-1:0] ls_fw,
  output logic [N_LS-1:0] ls_en_vds,
  // High-side pre-driver controls
  output logic [N_HS-1:0] hs_gate,
  output logic [N_HS-1:0][THR_W-1:0] hs_vds_thr,
  output logic [N_HS-1:0][THR_W-1:0] hs_src_thr,
  output logic [N_HS-1:0] hs_fw,
  output logic [N_HS-1:0] hs_en_vds,
  output logic [N_HS-1:0] hs_en_src
);
  logic [N_CORES-1:0][GRANT_W-1:0] grant;
  logic [GRANT_W-1:0] out_state;

  // The priority order and grant layout only fit four cores and one register word
  if (N_CORES != 4 || GRANT_W > REG_W) begin : g_bad_size
    $error("arbiter: unsupported sizes");
  end

  grant_regs u_regs (
    .clk(clk),
    .rst(rst),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .grant(grant),
    .out_state(out_state)
  );

  // Readback of the live gate values lets software see what the cores drive
  assign out_state = {ls_gate, hs_gate};

  // Low-side outputs
  generate
    for (genvar o = 0; o < N_LS; o++) begin : g_ls
      core_req_if #(.N(N_CORES), .W(LS_SET_W)) lsif ();
      for (genvar c = 0; c < N_CORES; c++) begin : g_core
        assign lsif.req[c] = ls_req[c][o];
        assign lsif.grant[c] = grant[c][GRANT_LS_LSB + o];
        assign lsif.locked[c] = core_locked[c];
        assign lsif.data[c][F_GATE] = ls_gate_in[c][o];
        assign lsif.data[c][F_VDS_LSB +: THR_W] = ls_vds_thr_in[c][o];
        assign lsif.data[c][F_FW] = ls_fw_in[c][o] & LS_FW_MASK[o];
        assign lsif.data[c][F_EN_VDS] = ls_en_vds_in[c][o];
      end
      output_merge #(.N(N_CORES), .W(LS_SET_W)) u_merge (
        .clk(clk),
        .rst(rst),
        .port(lsif.merge)
      );
      assign ls_gate[o] = lsif.q[F_GATE];
      assign ls_vds_thr[o] = lsif.q[F_VDS_LSB +: THR_W];
      assign ls_fw[o] = lsif.q[F_FW];
      assign ls_en_vds[o] = lsif.q[F_EN_VDS];
    end
  endgenerate

  // High-side outputs
  generate
    for (genvar o = 0; o < N_HS; o++) begin : g_hs
      core_req_if #(.N(N_CORES), .W(HS_SET_W)) hsif ();
      for (genvar c = 0; c < N_CORES; c++) begin : g_core
        assign hsif.req[c] = hs_req[c][o];
        assign hsif.grant[c] = grant[c][GRANT_HS_LSB + o];
        assign hsif.locked[c] = core_locked[c];
        assign hsif.data[c][F_GATE] = hs_gate_in[c][o];
        assign hsif.data[c][F_VDS_LSB +: THR_W] = hs_vds_thr_in[c][o];
        assign hsif.data[c][F_FW] = hs_fw_in[c][o] & HS_FW_MASK[o];
        assign hsif.data[c][F_EN_VDS] = hs_en_vds_in[c][o];
        assign hsif.data[c][F_SRC_LSB +: THR_W] = hs_src_thr_in[c][o];
        assign hsif.data[c][F_EN_SRC] = hs_en_src_in[c][o];
      end
      output_merge #(.N(N_CORES), .W(HS_SET_W)) u_merge (
        .clk(clk),
        .rst(rst),
        .port(hsif.merge)
      );
      assign hs_gate[o] = hsif.q[F_GATE];
      assign hs_vds_thr[o] = hsif.q[F_VDS_LSB +: THR_W];
      assign hs_fw[o] = hsif.q[F_FW];
      assign hs_en_vds[o] = hsif.q[F_EN_VDS];
      assign hs_src_thr[o] = hsif.q[F_SRC_LSB +: THR_W];
      assign hs_en_src[o] = hsif.q[F_EN_SRC];
    end
  endgenerate
endmodule // predriver_output_access_arbiter
`default_nettype wire

// *** bench/core_model.sv ***
/*
  Model of the four sequencer cores: one-cycle change strobes per output.
  Assumes the bench gives a core mask, output index (0-4 high, 5-11 low) and sets.
*/
`default_nettype none
module core_model
  import arb_pkg::*;
(
  // Clock
  input wire logic clk,
  // Bench commands
  input wire logic [N_CORES-1:0] go,
  input wire logic [3:0] o,
  input wire logic [N_CORES-1:0][9:0] val,
  // Core requests
  output logic [N_CORES-1:0][N_LS-1:0] ls_req,
  output logic [N_CORES-1:0][N_LS-1:0] ls_gate_in,
  output logic [N_CORES-1:0][N_LS-1:0][THR_W-1:0] ls_vds_thr_in,
  output logic [N_CORES-1:0][N_LS-1:0] ls_fw_in,
  output logic [N_CORES-1:0][N_LS-1:0] ls_en_vds_in,
  output logic [N_CORES-1:0][N_HS-1:0] hs_req,
  output logic [N_CORES-1:0][N_HS-1:0] hs_gate_in,
  output logic [N_CORES-1:0][N_HS-1:0][THR_W-1:0] hs_vds_thr_in,
  output logic [N_CORES-1:0][N_HS-1:0][THR_W-1:0] hs_src_thr_in,
  output logic [N_CORES-1:0][N_HS-1:0] hs_fw_in,
  output logic [N_CORES-1:0][N_HS-1:0] hs_en_vds_in,
  output logic [N_CORES-1:0][N_HS-1:0] hs_en_src_in
);
  initial begin
    {ls_req, ls_gate_in, ls_vds_thr_in, ls_fw_in, ls_en_vds_in} = '0;
    {hs_req, hs_gate_in, hs_vds_thr_in, hs_src_thr_in, hs_fw_in, hs_en_vds_in, hs_en_src_in} = '0;
  end
  always @(posedge clk) begin
    // Strobes only on a change, never held
    ls_req <= '0;
    hs_req <= '0;
    for (int c = 0; c < N_CORES; c++) begin
      if (go[c] && o < 4'h5) begin
        hs_req[c][o] <= 1'b1;
        {hs_en_src_in[c][o], hs_src_thr_in[c][o], hs_en_vds_in[c][o], hs_fw_in[c][o],
         hs_vds_thr_in[c][o], hs_gate_in[c][o]} <= val[c];
      end
      if (go[c] && o >= 4'h5) begin
        ls_req[c][o-5] <= 1'b1;
        {ls_en_vds_in[c][o-5], ls_fw_in[c][o-5], ls_vds_thr_in[c][o-5], ls_gate_in[c][o-5]} <= val[c][5:0];
      end
    end
  end
endmodule // core_model
`default_nettype wire

// *** bench/arbiter_checker.sv ***
/*
  Port-level assertions for the output access arbiter.
  Assumes the bench keeps the chan1_core0 grant on high side 1 set.
*/
`default_nettype none
module arbiter_checker
  import arb_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  // Requests
  input wire logic [N_CORES-1:0] core_locked,
  input wire logic [N_CORES-1:0][N_LS-1:0] ls_req,
  input wire logic [N_CORES-1:0][N_HS-1:0] hs_req,
  input wire logic [N_CORES-1:0][N_HS-1:0] hs_gate_in,
  // Merged controls
  input wire logic [N_LS-1:0] ls_gate,
  input wire logic [N_LS-1:0][THR_W-1:0] ls_vds_thr,
  input wire logic [N_LS-1:0] ls_fw,
  input wire logic [N_HS-1:0] hs_gate,
  input wire logic [N_HS-1:0][THR_W-1:0] hs_src_thr,
  input wire logic [N_HS-1:0] hs_fw,
  input wire logic [N_HS-1:0] hs_en_src
);
  logic [N_LS-1:0] ls_any;
  logic [N_HS-1:0] hs_any;
  assign ls_any = ls_req[0] | ls_req[1] | ls_req[2] | ls_req[3];
  assign hs_any = hs_req[0] | hs_req[1] | hs_req[2] | hs_req[3];
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  ls_fw_fixed_a: assert property (ls_fw[2:0] == 3'h0) else $error("low side fw set");
  hs_fw_fixed_a: assert property (hs_fw[3:0] == 4'h0) else $error("high side fw set");
  gate_cause_a: assert property ($rose(hs_gate[0]) |-> $past(hs_any[0])) else $error("hs gate rose");
  ls_cause_a: assert property ($rose(ls_gate[3]) |-> $past(ls_any[3])) else $error("ls gate rose");
  thr_hold_a: assert property (!ls_any[6] |=> $stable(ls_vds_thr[6])) else $error("ls thr moved");
  src_hold_a: assert property (!hs_any[1] |=> $stable(hs_src_thr[1])) else $error("src thr moved");
  src_check_a: assert property ($rose(hs_en_src[4]) |-> $past(hs_any[4])) else $error("src en rose");
  // Core0 is top priority and granted, so its unlocked pulse must end
  unlocked_pulse_a: assert property ((hs_req[0][0] && hs_gate_in[0][0] && !core_locked[0]) ##1 !hs_any[0]
    |=> !hs_gate[0]) else $error("gate not forced off");
  err_phase_a: assert property (pslverr |-> psel && penable) else $error("slverr out of access");
  misalign_err_a: assert property (psel && penable && paddr[1:0] != 2'h0 |-> pslverr)
    else $error("misaligned access not refused");
  upper_zero_a: assert property (psel && !penable && !pwrite && paddr[11:4] == 8'h61
    |=> prdata[31:12] == 20'h0) else $error("grant upper bits");
  cover property (hs_req[0][0] && hs_req[1][0]);
  cover property (pslverr);
  cover property ($fell(hs_gate[0]));
endmodule // arbiter_checker
bind predriver_output_access_arbiter arbiter_checker chk_i (.clk, .rst, .psel, .penable, .pwrite, .paddr,
  .prdata, .pslverr, .core_locked, .ls_req, .hs_req, .hs_gate_in, .ls_gate, .ls_vds_thr, .ls_fw, .hs_gate,
  .hs_src_thr, .hs_fw, .hs_en_src);
`default_nettype wire

// *** bench/predriver_output_access_arbiter_tb_top.sv ***
/*
  Self-checking bench: APB grant access, random core requests, priority and lock.
  Assumes the design, package, checker bind and core model are compiled first.
*/
`default_nettype none
module predriver_output_access_arbiter_tb_top
  import arb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [N_CORES-1:0] core_locked = '1, go = '0, l;
  logic [3:0] o = '0;
  logic [N_CORES-1:0][9:0] val = '0;
  logic [N_CORES-1:0][N_LS-1:0] ls_req, ls_gate_in, ls_fw_in, ls_en_vds_in;
  logic [N_CORES-1:0][N_LS-1:0][THR_W-1:0] ls_vds_thr_in;
  logic [N_CORES-1:0][N_HS-1:0] hs_req, hs_gate_in, hs_fw_in, hs_en_vds_in, hs_en_src_in;
  logic [N_CORES-1:0][N_HS-1:0][THR_W-1:0] hs_vds_thr_in, hs_src_thr_in;
  logic [N_LS-1:0] ls_gate, ls_fw, ls_en_vds;
  logic [N_LS-1:0][THR_W-1:0] ls_vds_thr;
  logic [N_HS-1:0] hs_gate, hs_fw, hs_en_vds, hs_en_src;
  logic [N_HS-1:0][THR_W-1:0] hs_vds_thr, hs_src_thr;
  logic [GRANT_W-1:0] g [N_CORES] = '{RST_GRANT_C0_CH1[11:0], RST_GRANT_C1_CH1[11:0],
    RST_GRANT_C0_CH2[11:0], RST_GRANT_C1_CH2[11:0]};
  logic [31:0] ex [GRANT_W] = '{default: '0};
  int failures = 0, samples_checked = 0;
  always #4 clk = ~clk;
  predriver_output_access_arbiter dut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .core_locked, .ls_req, .ls_gate_in, .ls_vds_thr_in, .ls_fw_in, .ls_en_vds_in, .hs_req, .hs_gate_in,
    .hs_vds_thr_in, .hs_src_thr_in, .hs_fw_in, .hs_en_vds_in, .hs_en_src_in, .ls_gate, .ls_vds_thr, .ls_fw,
    .ls_en_vds, .hs_gate, .hs_vds_thr, .hs_src_thr, .hs_fw, .hs_en_vds, .hs_en_src);
  core_model cores (.clk, .go, .o, .val, .ls_req, .ls_gate_in, .ls_vds_thr_in, .ls_fw_in, .ls_en_vds_in, .hs_req,
    .hs_gate_in, .hs_vds_thr_in, .hs_src_thr_in, .hs_fw_in, .hs_en_vds_in, .hs_en_src_in);
  task report_and_stop;
    if (failures == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] a, input logic [31:0] e);
    samples_checked++;
    if (a !== e) begin
      failures++;
      $display("ERROR t=%0t got %h exp %h", $time, a, e);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [31:0] fix(input int k, input logic [9:0] v);
    if (k >= N_HS) v[9:6] = 4'h0;
    if (k >= N_HS ? !LS_FW_MASK[k-N_HS] : !HS_FW_MASK[k]) v[F_FW] = 1'b0;
    return {22'h0, v};
  endfunction
  function automatic logic [31:0] act(input int k);
    if (k < N_HS) return {22'h0, hs_en_src[k], hs_src_thr[k], hs_en_vds[k], hs_fw[k], hs_vds_thr[k], hs_gate[k]};
    return {26'h0, ls_en_vds[k-N_HS], ls_fw[k-N_HS], ls_vds_thr[k-N_HS], ls_gate[k-N_HS]};
  endfunction
  task step(input logic [3:0] m, input int k);
    int w;
    logic [9:0] v [N_CORES];
    w = -1;
    l = 4'($urandom);
    @(posedge clk);
    for (int c = 3; c >= 0; c--) begin
      v[c] = 10'($urandom);
      if (m[c] && g[c][k]) w = c;
    end
    go <= m;
    o <= 4'(k);
    core_locked <= l;
    val <= {v[3], v[2], v[1], v[0]};
    @(posedge clk);
    go <= '0;
    if (w >= 0) ex[k] = fix(k, v[w]);
    @(posedge clk);
    #1 chk(act(k), ex[k]);
    if (w >= 0 && !l[w]) ex[k][F_GATE] = 1'b0;
    @(posedge clk);
    #1 chk(act(k), ex[k]);
  endtask
  initial begin
    #100000;
    failures++;
    report_and_stop;
  end
  initial begin
    int c;
    logic [31:0] d, e;
    void'($urandom(67227));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 12'(12'h610 + 4 * i), 32'h0);
      chk(rd, {20'h0, g[i]});
      apb(1'b1, 12'(12'h610 + 4 * i), 32'hFFFF_FFFF);
      g[i] = '1;
      apb(1'b0, 12'(12'h610 + 4 * i), 32'h0);
      chk(rd, 32'h0000_0FFF);
    end
    apb(1'b0, 12'h700, 32'h0);
    chk({er, rd[30:0]}, 32'h8000_0000);
    apb(1'b1, 12'h613, 32'h0);
    chk({31'h0, er}, 32'h1);
    for (int k = 0; k < 4; k++) step(4'(4'hF << k), k + 3);
    // Corner: chan1_core0 alone on high side 1, so unlocked switch-ons surely occur
    repeat (16) step(4'h1, 0);
    repeat (250) begin
      if ($urandom % 6 == 0) begin
        c = $urandom % 4;
        d = $urandom;
        // The pulse assertion relies on chan1_core0 owning high side 1
        d[0] = d[0] | (c == 0);
        apb(1'b1, 12'(12'h610 + 4 * c), d);
        g[c] = d[11:0];
      end
      step(4'($urandom), $urandom % 12);
    end
    e = '0;
    for (int i = 0; i < GRANT_W; i++) e[i] = ex[i][F_GATE];
    apb(1'b0, 12'h620, 32'h0);
    chk(rd, e);
    report_and_stop;
  end
endmodule // predriver_output_access_arbiter_tb_top
`default_nettype wire
